// >>> common/tglm_consts.svh
`ifndef TGLM_CONSTS_SVH
`define TGLM_CONSTS_SVH

// ==========================================
// Command byte layout on the control link
`define TGLM_COP(ch, tg) {2'b00, ch, 3'b110, tg}
`define TGLM_IS_COP(b) ((b[7:6] == 2'b00) && (b[3:1] == 3'b110))
`define TGLM_SOP_WR_HI 4'h8
`define TGLM_SOP_RD_HI 4'hc
`define TGLM_GAIN_HI 4'ha
`define TGLM_SOP_WR(sel, ch) {`TGLM_SOP_WR_HI, 1'b0, sel, ch}
`define TGLM_SOP_RD(sel, ch) {`TGLM_SOP_RD_HI, 1'b0, sel, ch}
`define TGLM_XOP_WR_OFS 8'h47
`define TGLM_XOP_RD_OFS 8'h67
`define TGLM_SEL_CR1 1'b0
`define TGLM_SEL_CR2 1'b1

// ==========================================
// Control register fields
`define TGLM_CR_W 3
`define TGLM_CR1_TG1 0
`define TGLM_CR1_TG2 1
`define TGLM_CR1_LOOP 2
`define TGLM_CR2_LM 0
`define TGLM_CR2_VPT 1
`define TGLM_CR2_OPER 2
`define TGLM_CR2_LMR 7
`define TGLM_CR2_LM_OPER 8'h05
`define TGLM_CR2_OPER_ONLY 8'h04

// ==========================================
// Reset values
`define TGLM_COEF_RST 32'h1b3b5087
`define TGLM_GAIN_RST 8'h40
`define TGLM_OFS_RST 8'h00
`define TGLM_SRCH_LO 8'h00
`define TGLM_SRCH_HI 8'hff

// ==========================================
// Level meter timing
`define TGLM_CLK_NS 50
`define TGLM_LM_WINDOW_NS 4000000
`define TGLM_LM_CYCLES (`TGLM_LM_WINDOW_NS / `TGLM_CLK_NS)
`define TGLM_TMR_W 17
// Filter field value 7 means no smoothing, 0 the slowest corner
`define TGLM_BP_SHIFT_MAX 3'h7

// ==========================================
// Host register map and operations
`define TGLM_H_CMD 4'h0
`define TGLM_H_DATA 4'h4
`define TGLM_H_STATUS 4'h8
`define TGLM_H_RESULT 4'hc
`define TGLM_OP_COEF 3'h0
`define TGLM_OP_CR1 3'h1
`define TGLM_OP_CR2 3'h2
`define TGLM_OP_OFS 3'h3
`define TGLM_OP_RD_CR2 3'h4
`define TGLM_OP_SEARCH 3'h5
`define TGLM_OP_GAIN 3'h6

`endif

// >>> common/tglm_link_if.sv
// ==========================================
// Byte command link between host and codec
interface tglm_link_if;
	logic cmd_valid;
	logic [7:0] cmd_byte;
	logic rsp_valid;
	logic [7:0] rsp_byte;
	modport dev (input cmd_valid, input cmd_byte, output rsp_valid, output rsp_byte);
	modport host (output cmd_valid, output cmd_byte, input rsp_valid, input rsp_byte);
endinterface : tglm_link_if

// >>> common/tglm_pkg.sv
package tglm_pkg;
	typedef logic signed [15:0] tglm_smp_t;
	typedef enum logic [0:0] {TGLM_D_IDLE, TGLM_D_PARAM} tglm_dev_state_t;
	typedef enum logic [2:0] {TGLM_K_COEF, TGLM_K_CR1, TGLM_K_CR2, TGLM_K_GAIN, TGLM_K_OFS} tglm_kind_t;
	typedef enum logic [1:0] {TGLM_H_IDLE, TGLM_H_SEND, TGLM_H_RSP, TGLM_H_WAIT} tglm_host_state_t;
	typedef enum logic [1:0] {TGLM_S_NONE, TGLM_S_SETUP, TGLM_S_PROBE} tglm_srch_t;
endpackage : tglm_pkg

// >>> hdl/tglm_device.sv
// Behaviour
// RULE1 - two tone generators, switched by control writes
// RULE2 - frequency loaded by command plus four bytes
// RULE3 - tone on without voice-plus-tone mutes voice
// RULE4 - tone path has programmable bandpass filter
// RULE5 - default coefficients give 1000 Hz tone
// RULE6 - codes 0C/0D select channel 1 generators
// RULE7 - four bytes set tone and bandpass
// RULE8 - receive gain filters set tone amplitude
// RULE9 - digital loop feeds tone into transmit
// RULE10 - meter filter uses second generator coefficients
// RULE11 - filtered transmit rectified, compared with offset
// RULE12 - compare bit one above offset, else zero
// RULE13 - one shared 8-bit offset, extended command
// RULE14 - host keeps partner channel operating
// RULE15 - host starts search at mid-range byte
// RULE16 - host stops at adjacent bytes one/zero
// RULE17 - result valid after 4 ms, refreshed 4 ms
// RULE18 - meter enable switches off second generator
// RULE19 - offset kept across meter enable changes
`include "tglm_consts.svh"

module tglm_device #(
	parameter int unsigned LM_CYCLES = `TGLM_LM_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	tglm_link_if.dev link,
	input wire logic i_sample,
	input wire logic [3:0][15:0] i_rx_voice,
	input wire logic [3:0][15:0] i_tx_voice,
	output logic [3:0][15:0] o_rx_out,
	output logic [3:0][15:0] o_tx_out
);

	// ==========================================
	// Arithmetic helpers
	// Triangle stands in for the sine table to save area
	function automatic tglm_pkg::tglm_smp_t tglm_tri(input logic [15:0] ph);
		logic [13:0] t;
		t = ph[14] ? ~ph[13:0] : ph[13:0];
		return ph[15] ? -$signed({2'b00, t}) : $signed({2'b00, t});
	endfunction : tglm_tri

	// Gain byte 8'h40 is unity
	function automatic tglm_pkg::tglm_smp_t tglm_gain(input tglm_pkg::tglm_smp_t x, input logic [7:0] g);
		logic signed [24:0] p;
		p = x * $signed({1'b0, g});
		return p[21:6];
	endfunction : tglm_gain

	// Low-pass then high-pass difference then low-pass: a two-shift bandpass
	// Fields map to shifts inverted, so the default bytes pass the tone instead of cancelling it
	function automatic logic [31:0] tglm_bp(input tglm_pkg::tglm_smp_t x, input tglm_pkg::tglm_smp_t a,
		input tglm_pkg::tglm_smp_t b, input logic [7:0] ka, input logic [7:0] kb);
		logic signed [16:0] d;
		tglm_pkg::tglm_smp_t an;
		tglm_pkg::tglm_smp_t hp;
		d = x - a;
		an = a + 16'(d >>> (`TGLM_BP_SHIFT_MAX - ka[2:0])); // [RULE4]
		hp = 16'(x - an);
		d = hp - b;
		return {an, 16'(b + 16'(d >>> (`TGLM_BP_SHIFT_MAX - kb[2:0])))};
	endfunction : tglm_bp

	// ==========================================
	// Command parser state and control registers
	tglm_pkg::tglm_dev_state_t st_r, st_nxt;
	tglm_pkg::tglm_kind_t kind_r, kind_nxt;
	logic [1:0] ch_r, ch_nxt;
	logic sel_r, sel_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic [23:0] stage_r, stage_nxt;
	logic [31:0] coef_r [4][2];
	logic [31:0] coef_nxt [4][2];
	logic [7:0] gain_r [4][2];
	logic [7:0] gain_nxt [4][2];
	logic [`TGLM_CR_W-1:0] cr1_r [4];
	logic [`TGLM_CR_W-1:0] cr1_nxt [4];
	logic [`TGLM_CR_W-1:0] cr2_r [4];
	logic [`TGLM_CR_W-1:0] cr2_nxt [4];
	logic [7:0] ofs_r, ofs_nxt;
	logic rsp_v_r, rsp_v_nxt;
	logic [7:0] rsp_b_r, rsp_b_nxt;
	logic [3:0] lmr_r, lmr_nxt;

	// Decode one byte a cycle; the host is never stalled
	always_comb
	begin
		logic [7:0] b;
		b = link.cmd_byte;
		st_nxt = st_r;
		kind_nxt = kind_r;
		ch_nxt = ch_r;
		sel_nxt = sel_r;
		cnt_nxt = cnt_r;
		stage_nxt = stage_r;
		coef_nxt = coef_r;
		gain_nxt = gain_r;
		cr1_nxt = cr1_r;
		cr2_nxt = cr2_r;
		ofs_nxt = ofs_r;
		rsp_v_nxt = 1'b0;
		rsp_b_nxt = rsp_b_r;
		if (!i_nrst)
		begin
			st_nxt = tglm_pkg::TGLM_D_IDLE;
			kind_nxt = tglm_pkg::TGLM_K_COEF;
			ch_nxt = 2'h0;
			sel_nxt = 1'b0;
			cnt_nxt = 2'h0;
			stage_nxt = 24'h000000;
			ofs_nxt = `TGLM_OFS_RST;
			rsp_b_nxt = 8'h00;
			for (int c = 0; c < 4; c++)
			begin
				cr1_nxt[c] = '0;
				cr2_nxt[c] = '0;
				for (int t = 0; t < 2; t++)
				begin
					coef_nxt[c][t] = `TGLM_COEF_RST; // [RULE5]
					gain_nxt[c][t] = `TGLM_GAIN_RST;
				end
			end
		end
		else if (link.cmd_valid && st_r == tglm_pkg::TGLM_D_IDLE)
		begin
			ch_nxt = b[1:0];
			if (`TGLM_IS_COP(b))
			begin
				kind_nxt = tglm_pkg::TGLM_K_COEF; // [RULE2] [RULE6]
				ch_nxt = b[5:4];
				sel_nxt = b[0];
				cnt_nxt = 2'h0;
				st_nxt = tglm_pkg::TGLM_D_PARAM;
			end
			else if (b[7:4] == `TGLM_SOP_WR_HI)
			begin
				kind_nxt = b[2] ? tglm_pkg::TGLM_K_CR2 : tglm_pkg::TGLM_K_CR1;
				st_nxt = tglm_pkg::TGLM_D_PARAM;
			end
			else if (b[7:4] == `TGLM_GAIN_HI)
			begin
				kind_nxt = tglm_pkg::TGLM_K_GAIN;
				sel_nxt = b[2];
				st_nxt = tglm_pkg::TGLM_D_PARAM;
			end
			else if (b == `TGLM_XOP_WR_OFS)
			begin
				kind_nxt = tglm_pkg::TGLM_K_OFS; // [RULE13]
				st_nxt = tglm_pkg::TGLM_D_PARAM;
			end
			else if (b[7:4] == `TGLM_SOP_RD_HI)
			begin
				rsp_v_nxt = 1'b1;
				rsp_b_nxt = 8'h00;
				if (b[2])
				begin
					rsp_b_nxt[`TGLM_CR_W-1:0] = cr2_r[b[1:0]];
					rsp_b_nxt[`TGLM_CR2_LMR] = lmr_r[b[1:0]]; // [RULE12]
				end
				else
				begin
					rsp_b_nxt[`TGLM_CR_W-1:0] = cr1_r[b[1:0]];
				end
			end
			else if (b == `TGLM_XOP_RD_OFS)
			begin
				rsp_v_nxt = 1'b1;
				rsp_b_nxt = ofs_r;
			end
		end
		else if (link.cmd_valid)
		begin
			st_nxt = tglm_pkg::TGLM_D_IDLE;
			unique case (kind_r)
				tglm_pkg::TGLM_K_COEF:
				begin
					// Commit only on the fourth byte so a half load never plays
					if (cnt_r == 2'h3)
					begin
						coef_nxt[ch_r][sel_r] = {stage_r, b}; // [RULE2] [RULE7]
					end
					else
					begin
						stage_nxt = {stage_r[15:0], b};
						cnt_nxt = cnt_r + 2'h1;
						st_nxt = tglm_pkg::TGLM_D_PARAM;
					end
				end
				tglm_pkg::TGLM_K_CR1: cr1_nxt[ch_r] = b[`TGLM_CR_W-1:0]; // [RULE1]
				tglm_pkg::TGLM_K_CR2:
				begin
					cr2_nxt[ch_r] = b[`TGLM_CR_W-1:0];
					if (b[`TGLM_CR2_LM])
					begin
						cr1_nxt[ch_r][`TGLM_CR1_TG2] = 1'b0; // [RULE18]
					end
				end
				tglm_pkg::TGLM_K_GAIN: gain_nxt[ch_r][sel_r] = b; // [RULE8]
				tglm_pkg::TGLM_K_OFS: ofs_nxt = b; // [RULE13] [RULE19]
			endcase
		end
	end

	// Control registers
	always_ff @(posedge i_ref_clk)
	begin
		st_r <= st_nxt;
		kind_r <= kind_nxt;
		ch_r <= ch_nxt;
		sel_r <= sel_nxt;
		cnt_r <= cnt_nxt;
		stage_r <= stage_nxt;
		coef_r <= coef_nxt;
		gain_r <= gain_nxt;
		cr1_r <= cr1_nxt;
		cr2_r <= cr2_nxt;
		ofs_r <= ofs_nxt;
		rsp_v_r <= rsp_v_nxt;
		rsp_b_r <= rsp_b_nxt;
	end

	assign link.rsp_valid = rsp_v_r;
	assign link.rsp_byte = rsp_b_r;

	// ==========================================
	// Tone, voice and level meter path
	logic [15:0] ph_r [4][2];
	logic [15:0] ph_nxt [4][2];
	logic [31:0] tf_r [4];
	logic [31:0] tf_nxt [4];
	logic [31:0] mf_r [4];
	logic [31:0] mf_nxt [4];
	logic [19:0] acc_r [4];
	logic [19:0] acc_nxt [4];
	logic [`TGLM_TMR_W-1:0] tmr_r [4];
	logic [`TGLM_TMR_W-1:0] tmr_nxt [4];
	logic [3:0][15:0] rx_r, rx_nxt, tx_r, tx_nxt;

	// Everything moves on the sample strobe except the meter window timer, its end-of-window compare and sum clear, and the meter clear while off
	always_comb
	begin
		logic [1:0] on;
		tglm_pkg::tglm_smp_t tone;
		tglm_pkg::tglm_smp_t tx;
		tglm_pkg::tglm_smp_t mag;
		on = 2'b00;
		tone = '0;
		tx = '0;
		mag = '0;
		ph_nxt = ph_r;
		tf_nxt = tf_r;
		mf_nxt = mf_r;
		acc_nxt = acc_r;
		tmr_nxt = tmr_r;
		lmr_nxt = lmr_r;
		rx_nxt = rx_r;
		tx_nxt = tx_r;
		for (int c = 0; c < 4; c++)
		begin
			on[0] = cr1_r[c][`TGLM_CR1_TG1]; // [RULE1]
			on[1] = cr1_r[c][`TGLM_CR1_TG2] && !cr2_r[c][`TGLM_CR2_LM]; // [RULE18]
			tone = tglm_gain(tglm_gain($signed(tf_r[c][15:0]), gain_r[c][0]), gain_r[c][1]); // [RULE8]
			if (i_sample)
			begin
				for (int t = 0; t < 2; t++)
				begin
					ph_nxt[c][t] = on[t] ? ph_r[c][t] + coef_r[c][t][31:16] : 16'h0000; // [RULE7]
				end
				// Bytes 3 and 4 of the first generator shape the tone filter
				tf_nxt[c] = tglm_bp((on[0] ? tglm_tri(ph_r[c][0]) >>> 1 : 16'sh0000)
					+ (on[1] ? tglm_tri(ph_r[c][1]) >>> 1 : 16'sh0000),
					$signed(tf_r[c][31:16]), $signed(tf_r[c][15:0]),
					coef_r[c][0][15:8], coef_r[c][0][7:0]); // [RULE4]
				if (on != 2'b00 && !cr2_r[c][`TGLM_CR2_VPT])
				begin
					rx_nxt[c] = tone; // [RULE3]
				end
				else if (on != 2'b00)
				begin
					rx_nxt[c] = ($signed(i_rx_voice[c]) >>> 1) + (tone >>> 1);
				end
				else
				begin
					rx_nxt[c] = i_rx_voice[c];
				end
				tx = cr1_r[c][`TGLM_CR1_LOOP] ? tone : $signed(i_tx_voice[c]); // [RULE9]
				tx_nxt[c] = tx;
			end
			if (!cr2_r[c][`TGLM_CR2_LM])
			begin
				mf_nxt[c] = 32'h00000000;
				acc_nxt[c] = 20'h00000;
				tmr_nxt[c] = '0;
				lmr_nxt[c] = 1'b0;
			end
			else
			begin
				if (i_sample)
				begin
					mf_nxt[c] = tglm_bp(tx, $signed(mf_r[c][31:16]), $signed(mf_r[c][15:0]),
						coef_r[c][1][15:8], coef_r[c][1][7:0]); // [RULE10]
					mag = mf_r[c][15] ? 16'(-$signed(mf_r[c][15:0])) : $signed(mf_r[c][15:0]); // [RULE11]
					acc_nxt[c] = acc_r[c] + {4'h0, mag};
				end
				// Fixed window: a result stands for one whole window, then is replaced
				if (tmr_r[c] == `TGLM_TMR_W'(LM_CYCLES - 1))
				begin
					lmr_nxt[c] = acc_r[c][19:12] > ofs_r; // [RULE11] [RULE12] [RULE17]
					acc_nxt[c] = 20'h00000;
					tmr_nxt[c] = '0;
				end
				else
				begin
					tmr_nxt[c] = tmr_r[c] + `TGLM_TMR_W'(1);
				end
			end
			if (!i_nrst)
			begin
				ph_nxt[c] = '{16'h0000, 16'h0000};
				tf_nxt[c] = 32'h00000000;
				mf_nxt[c] = 32'h00000000;
				acc_nxt[c] = 20'h00000;
				tmr_nxt[c] = '0;
				lmr_nxt[c] = 1'b0;
				rx_nxt[c] = 16'h0000;
				tx_nxt[c] = 16'h0000;
			end
		end
	end

	// Signal path registers
	always_ff @(posedge i_ref_clk)
	begin
		ph_r <= ph_nxt;
		tf_r <= tf_nxt;
		mf_r <= mf_nxt;
		acc_r <= acc_nxt;
		tmr_r <= tmr_nxt;
		lmr_r <= lmr_nxt;
		rx_r <= rx_nxt;
		tx_r <= tx_nxt;
	end

	assign o_rx_out = rx_r;
	assign o_tx_out = tx_r;

endmodule : tglm_device

// >>> hdl/tglm_host.sv
`include "tglm_consts.svh"

module tglm_host #(
	parameter int unsigned LM_CYCLES = `TGLM_LM_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	tglm_link_if.host link,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata
);

	// ==========================================
	// Sequencer state
	tglm_pkg::tglm_host_state_t st_r, st_nxt;
	tglm_pkg::tglm_srch_t srch_r, srch_nxt;
	logic [7:0] buf_r [5];
	logic [7:0] buf_nxt [5];
	logic [2:0] len_r, len_nxt, ptr_r, ptr_nxt;
	logic rd_r, rd_nxt;
	logic [1:0] ch_r, ch_nxt;
	logic [`TGLM_TMR_W-1:0] tmr_r, tmr_nxt;
	logic [7:0] lo_r, lo_nxt, hi_r, hi_nxt, res_r, res_nxt, last_r, last_nxt;
	logic [31:0] data_r, data_nxt, rdata_r, rdata_nxt;
	logic cv_r, cv_nxt;
	logic [7:0] cb_r, cb_nxt;

	function automatic logic [7:0] tglm_mid(input logic [7:0] lo, input logic [7:0] hi);
		logic [8:0] s;
		s = {1'b0, lo} + {1'b0, hi};
		return s[8:1];
	endfunction : tglm_mid

	// Register port, command start and link byte sequencing
	always_comb
	begin
		logic [7:0] nlo;
		logic [7:0] nhi;
		nlo = lo_r;
		nhi = hi_r;
		st_nxt = st_r;
		srch_nxt = srch_r;
		buf_nxt = buf_r;
		len_nxt = len_r;
		ptr_nxt = ptr_r;
		rd_nxt = rd_r;
		ch_nxt = ch_r;
		tmr_nxt = tmr_r;
		lo_nxt = lo_r;
		hi_nxt = hi_r;
		res_nxt = res_r;
		last_nxt = last_r;
		data_nxt = data_r;
		rdata_nxt = 32'h00000000;
		cv_nxt = 1'b0;
		cb_nxt = cb_r;
		if (i_rd)
		begin
			unique case (i_addr)
				`TGLM_H_DATA: rdata_nxt = data_r;
				`TGLM_H_STATUS: rdata_nxt = {31'h00000000, st_r != tglm_pkg::TGLM_H_IDLE};
				`TGLM_H_RESULT: rdata_nxt = {16'h0000, last_r, res_r};
				default: rdata_nxt = 32'h00000000;
			endcase
		end
		if (i_wr && i_addr == `TGLM_H_DATA)
		begin
			data_nxt = i_wdata;
		end
		unique case (st_r)
			tglm_pkg::TGLM_H_IDLE:
			begin
				// New orders are ignored while a sequence runs
				if (i_wr && i_addr == `TGLM_H_CMD)
				begin
					ch_nxt = i_wdata[5:4];
					ptr_nxt = 3'h0;
					rd_nxt = 1'b0;
					st_nxt = tglm_pkg::TGLM_H_SEND;
					len_nxt = 3'h2;
					buf_nxt[1] = data_r[7:0];
					unique case (i_wdata[2:0])
						`TGLM_OP_COEF:
						begin
							buf_nxt = '{`TGLM_COP(i_wdata[5:4], i_wdata[6]), data_r[31:24], data_r[23:16],
								data_r[15:8], data_r[7:0]}; // [RULE2] [RULE6] [RULE7]
							len_nxt = 3'h5;
						end
						`TGLM_OP_CR1: buf_nxt[0] = `TGLM_SOP_WR(`TGLM_SEL_CR1, i_wdata[5:4]);
						`TGLM_OP_CR2: buf_nxt[0] = `TGLM_SOP_WR(`TGLM_SEL_CR2, i_wdata[5:4]);
						`TGLM_OP_OFS: buf_nxt[0] = `TGLM_XOP_WR_OFS;
						`TGLM_OP_GAIN: buf_nxt[0] = {`TGLM_GAIN_HI, 1'b0, i_wdata[6], i_wdata[5:4]};
						`TGLM_OP_RD_CR2:
						begin
							buf_nxt[0] = `TGLM_SOP_RD(`TGLM_SEL_CR2, i_wdata[5:4]);
							len_nxt = 3'h1;
							rd_nxt = 1'b1;
						end
						`TGLM_OP_SEARCH:
						begin
							lo_nxt = `TGLM_SRCH_LO;
							hi_nxt = `TGLM_SRCH_HI;
							srch_nxt = tglm_pkg::TGLM_S_SETUP;
							buf_nxt[0] = `TGLM_SOP_WR(`TGLM_SEL_CR2, i_wdata[5:4]);
							buf_nxt[1] = `TGLM_CR2_LM_OPER;
							if (i_wdata[4])
							begin
								// Partner channel must be operating first
								buf_nxt[0] = `TGLM_SOP_WR(`TGLM_SEL_CR2, {i_wdata[5], 1'b0}); // [RULE14]
								buf_nxt[1] = `TGLM_CR2_OPER_ONLY;
								buf_nxt[2] = `TGLM_SOP_WR(`TGLM_SEL_CR2, i_wdata[5:4]);
								buf_nxt[3] = `TGLM_CR2_LM_OPER;
								len_nxt = 3'h4;
							end
						end
						default: st_nxt = tglm_pkg::TGLM_H_IDLE;
					endcase
				end
			end
			tglm_pkg::TGLM_H_SEND:
			begin
				cv_nxt = 1'b1;
				cb_nxt = buf_r[ptr_r];
				ptr_nxt = ptr_r + 3'h1;
				if (ptr_r == len_r - 3'h1)
				begin
					ptr_nxt = 3'h0;
					if (rd_r)
					begin
						st_nxt = tglm_pkg::TGLM_H_RSP;
					end
					else if (srch_r == tglm_pkg::TGLM_S_SETUP)
					begin
						buf_nxt[0] = `TGLM_XOP_WR_OFS;
						buf_nxt[1] = tglm_mid(lo_r, hi_r); // [RULE15]
						len_nxt = 3'h2;
						srch_nxt = tglm_pkg::TGLM_S_PROBE;
					end
					else if (srch_r == tglm_pkg::TGLM_S_PROBE)
					begin
						tmr_nxt = '0;
						st_nxt = tglm_pkg::TGLM_H_WAIT;
					end
					else
					begin
						st_nxt = tglm_pkg::TGLM_H_IDLE;
					end
				end
			end
			tglm_pkg::TGLM_H_WAIT:
			begin
				// One full window after the offset change before looking
				tmr_nxt = tmr_r + `TGLM_TMR_W'(1);
				if (tmr_r == `TGLM_TMR_W'(LM_CYCLES)) // [RULE17]
				begin
					buf_nxt[0] = `TGLM_SOP_RD(`TGLM_SEL_CR2, ch_r);
					len_nxt = 3'h1;
					rd_nxt = 1'b1;
					st_nxt = tglm_pkg::TGLM_H_SEND;
				end
			end
			tglm_pkg::TGLM_H_RSP:
			begin
				if (link.rsp_valid)
				begin
					last_nxt = link.rsp_byte;
					rd_nxt = 1'b0;
					st_nxt = tglm_pkg::TGLM_H_IDLE;
					if (srch_r == tglm_pkg::TGLM_S_PROBE)
					begin
						if (link.rsp_byte[`TGLM_CR2_LMR])
						begin
							nlo = tglm_mid(lo_r, hi_r); // [RULE15]
						end
						else
						begin
							nhi = tglm_mid(lo_r, hi_r);
						end
						lo_nxt = nlo;
						hi_nxt = nhi;
						if (nhi == nlo + 8'h01)
						begin
							res_nxt = nlo; // [RULE16]
							srch_nxt = tglm_pkg::TGLM_S_NONE;
						end
						else
						begin
							buf_nxt[0] = `TGLM_XOP_WR_OFS;
							buf_nxt[1] = tglm_mid(nlo, nhi);
							len_nxt = 3'h2;
							st_nxt = tglm_pkg::TGLM_H_SEND;
						end
					end
				end
			end
		endcase
		if (!i_nrst)
		begin
			st_nxt = tglm_pkg::TGLM_H_IDLE;
			srch_nxt = tglm_pkg::TGLM_S_NONE;
			buf_nxt = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
			len_nxt = 3'h0;
			ptr_nxt = 3'h0;
			rd_nxt = 1'b0;
			ch_nxt = 2'h0;
			tmr_nxt = '0;
			lo_nxt = `TGLM_SRCH_LO;
			hi_nxt = `TGLM_SRCH_HI;
			res_nxt = 8'h00;
			last_nxt = 8'h00;
			data_nxt = 32'h00000000;
			rdata_nxt = 32'h00000000;
			cv_nxt = 1'b0;
			cb_nxt = 8'h00;
		end
	end

	// Sequencer registers
	always_ff @(posedge i_ref_clk)
	begin
		st_r <= st_nxt;
		srch_r <= srch_nxt;
		buf_r <= buf_nxt;
		len_r <= len_nxt;
		ptr_r <= ptr_nxt;
		rd_r <= rd_nxt;
		ch_r <= ch_nxt;
		tmr_r <= tmr_nxt;
		lo_r <= lo_nxt;
		hi_r <= hi_nxt;
		res_r <= res_nxt;
		last_r <= last_nxt;
		data_r <= data_nxt;
		rdata_r <= rdata_nxt;
		cv_r <= cv_nxt;
		cb_r <= cb_nxt;
	end

	assign link.cmd_valid = cv_r;
	assign link.cmd_byte = cb_r;
	assign o_rdata = rdata_r;

endmodule : tglm_host

// >>> verification/tglm_link_assertions.sv
`include "tglm_consts.svh"

// ==========================================
// Link protocol checks
module tglm_link_assertions #(
	parameter int unsigned LM_CYCLES = 64
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_byte
);
	logic [2:0] prm_r;
	logic [2:0] prm_nxt;
	int unsigned wait_r;
	int unsigned wait_nxt;
	logic first;
	logic is_rd;
	logic rd_cr2;
	logic one_prm;

	// Frame decode, so a data byte never passes for a command
	assign first = cmd_valid && (prm_r == 3'h0);
	assign is_rd = first && ((cmd_byte[7:3] == 5'h18) || (cmd_byte == `TGLM_XOP_RD_OFS));
	assign rd_cr2 = is_rd && (cmd_byte[7:2] == 6'h31);
	assign one_prm = (cmd_byte == `TGLM_XOP_WR_OFS) || (cmd_byte[7:4] == `TGLM_SOP_WR_HI)
		|| (cmd_byte[7:4] == `TGLM_GAIN_HI);

	// Parameter countdown and meter settle timer (saturates, avoids wrap)
	always_comb
	begin
		prm_nxt = prm_r;
		wait_nxt = (wait_r < LM_CYCLES) ? wait_r + 1 : wait_r;
		if (cmd_valid && (prm_r != 3'h0))
			prm_nxt = prm_r - 3'h1;
		else if (first && `TGLM_IS_COP(cmd_byte))
			prm_nxt = 3'h4;
		else if (first && one_prm)
			prm_nxt = 3'h1;
		if (first && ((cmd_byte == `TGLM_XOP_WR_OFS) || (cmd_byte[7:2] == 6'h21)))
			wait_nxt = 0;
	end

	always_ff @(posedge i_ref_clk)
	begin
		prm_r <= i_nrst ? prm_nxt : 3'h0;
		wait_r <= i_nrst ? wait_nxt : LM_CYCLES;
	end

	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);

	// ==========================================
	// Assertions
	a_read_answer_next: assert property (is_rd |=> rsp_valid)
		else $error("read command got no answer one cycle later");
	a_answer_has_cause: assert property (rsp_valid |-> $past(is_rd))
		else $error("answer without a read command");
	a_answer_one_cycle: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer valid longer than one cycle");
	a_answer_byte_holds: assert property (!rsp_valid |-> $stable(rsp_byte))
		else $error("answer byte changed without answer");
	a_cr2_read_format: assert property (rsp_valid && $past(rd_cr2) |-> rsp_byte[6:3] == 4'h0)
		else $error("control read has unused bits set");
	a_coef_four_bytes: assert property (first && `TGLM_IS_COP(cmd_byte) |=> cmd_valid [*4])
		else $error("coefficient command not followed by four bytes");
	a_param_follows: assert property (first && one_prm |=> cmd_valid)
		else $error("single parameter byte missing");
	a_meter_wait: assert property (rd_cr2 |-> wait_r >= LM_CYCLES)
		else $error("compare result read before settle time");

	c_read_answer: cover property (is_rd ##1 rsp_valid);
	c_coef_load: cover property (first && `TGLM_IS_COP(cmd_byte));
	c_level_high: cover property (rsp_valid && rsp_byte[7]);
endmodule : tglm_link_assertions

// >>> verification/tglm_tb.sv
`include "tglm_consts.svh"

module tglm_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned LM = 512;
	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_sample = 1'b0;
	logic smp_free = 1'b0;
	logic smp_req = 1'b0;
	logic [2:0] smp_div = 3'h0;
	logic [3:0][15:0] rx_v = '0;
	logic [3:0][15:0] tx_v = '0;
	logic [3:0][15:0] rx_o;
	logic [3:0][15:0] tx_o;
	logic [3:0] addr = '0;
	logic [31:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [31:0] got;
	logic [7:0] res;
	logic seen;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;

	// ==========================================
	// Clock, sample strobe and hang guard
	always #25 i_ref_clk = ~i_ref_clk;
	// Free strobe every eighth cycle keeps the meter sum inside its width
	always @(posedge i_ref_clk)
	begin
		smp_div <= smp_div + 3'h1;
		i_sample <= smp_free ? (smp_div == 3'h0) : smp_req;
	end
	always @(posedge i_ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			n_mismatch = n_mismatch + 1;
			report_and_stop();
		end
	end

	tglm_link_if u_tglm_link_if();
	tglm_device #(.LM_CYCLES(LM)) u_tglm_device (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .link(u_tglm_link_if),
		.i_sample(i_sample), .i_rx_voice(rx_v), .i_tx_voice(tx_v), .o_rx_out(rx_o), .o_tx_out(tx_o));
	tglm_host #(.LM_CYCLES(LM)) u_tglm_host (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .link(u_tglm_link_if),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
	tglm_link_assertions #(.LM_CYCLES(LM)) u_tglm_link_assertions (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
		.cmd_valid(u_tglm_link_if.cmd_valid), .cmd_byte(u_tglm_link_if.cmd_byte),
		.rsp_valid(u_tglm_link_if.rsp_valid), .rsp_byte(u_tglm_link_if.rsp_byte));

	// ==========================================
	// Access tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done = checks_done + 1;
		if (g !== e)
		begin
			n_mismatch = n_mismatch + 1;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_ref_clk);
		wr <= 1'b0;
	endtask : reg_wr

	// Read data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_ref_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : reg_rd

	// Data first, then command; poll busy under the hang guard
	task automatic op(input logic [2:0] code, input logic [1:0] ch, input logic [31:0] d);
		logic [31:0] s;
		reg_wr(`TGLM_H_DATA, d);
		reg_wr(`TGLM_H_CMD, {25'h0, 1'b0, ch, 1'b0, code});
		s = 32'h1;
		while (s[0] !== 1'b0)
			reg_rd(`TGLM_H_STATUS, s);
	endtask : op

	// One sample strobe, then let the outputs settle
	task automatic pulse();
		@(posedge i_ref_clk);
		smp_req <= 1'b1;
		@(posedge i_ref_clk);
		smp_req <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		#1;
	endtask : pulse

	task automatic cmp_ch(input logic exp_diff);
		seen = 1'b0;
		repeat (12)
		begin
			pulse();
			seen = seen | (rx_o[0] !== rx_o[1]);
		end
		chk({31'h0, seen}, {31'h0, exp_diff});
	endtask : cmp_ch

	// Offset, settle a full window, then read the compare bit
	task automatic lm_at(input logic [7:0] ofs, input logic exp);
		op(`TGLM_OP_OFS, 2'h0, {24'h0, ofs});
		repeat (LM + 8) @(posedge i_ref_clk);
		op(`TGLM_OP_RD_CR2, 2'h1, 32'h0);
		reg_rd(`TGLM_H_RESULT, got);
		chk({16'h0, got[15:8]}, {16'h0, exp, 7'h05});
	endtask : lm_at

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	// ==========================================
	// Test sequence
	initial
	begin
		repeat (3) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		reg_rd(`TGLM_H_STATUS, got);
		chk(got, 32'h0);
		reg_rd(`TGLM_H_RESULT, got);
		chk(got, 32'h0);
		reg_rd(4'h2, got);
		chk(got, 32'h0);
		reg_wr(`TGLM_H_DATA, 32'h5a5a_c3c3);
		reg_rd(`TGLM_H_DATA, got);
		chk(got, 32'h5a5a_c3c3);
		$display("test register map done");
		// Same default tone, different voice: muted outputs must match
		op(`TGLM_OP_CR2, 2'h0, 32'h4);
		op(`TGLM_OP_CR2, 2'h1, 32'h4);
		op(`TGLM_OP_CR1, 2'h0, 32'h1);
		op(`TGLM_OP_CR1, 2'h1, 32'h1);
		@(posedge i_ref_clk);
		rx_v[1] <= 16'h1000;
		cmp_ch(1'b0);
		op(`TGLM_OP_CR2, 2'h1, 32'h6);
		cmp_ch(1'b1);
		op(`TGLM_OP_CR2, 2'h1, 32'h4);
		cmp_ch(1'b0);
		op(`TGLM_OP_COEF, 2'h0, 32'h91b2_50ab);
		cmp_ch(1'b1);
		$display("test tone and mute done");
		// Looped tone reaches transmit, unlooped channel stays silent
		op(`TGLM_OP_CR2, 2'h2, 32'h4);
		op(`TGLM_OP_CR1, 2'h2, 32'h5);
		seen = 1'b0;
		repeat (8)
		begin
			pulse();
			seen = seen | (tx_o[2] !== 16'h0);
		end
		chk({31'h0, seen}, 32'h1);
		chk({16'h0, tx_o[3]}, 32'h0);
		// Zero receive gain silences the looped tone
		op(`TGLM_OP_GAIN, 2'h2, 32'h0);
		repeat (2) pulse();
		chk({16'h0, tx_o[2]}, 32'h0);
		$display("test digital loop done");
		// Level search on looped tone, then bracket the found byte
		op(`TGLM_OP_CR1, 2'h1, 32'h5);
		smp_free <= 1'b1;
		op(`TGLM_OP_SEARCH, 2'h1, 32'h0);
		reg_rd(`TGLM_H_RESULT, got);
		res = got[7:0];
		// Margins cover the spread of a window that holds no whole number of periods
		if (res < 8'hf0)
			lm_at(res + 8'h10, 1'b0);
		if (res > 8'h10)
			lm_at(res - 8'h10, 1'b1);
		// Offset must survive a meter off/on cycle
		if (res > 8'h10)
		begin
			op(`TGLM_OP_CR2, 2'h1, 32'h4);
			op(`TGLM_OP_CR2, 2'h1, 32'h5);
			repeat (LM + 8) @(posedge i_ref_clk);
			op(`TGLM_OP_RD_CR2, 2'h1, 32'h0);
			reg_rd(`TGLM_H_RESULT, got);
			chk({24'h0, got[15:8]}, 32'h85);
		end
		// Blocking filter on the second generator of channel 1 drops the level to zero
		reg_wr(`TGLM_H_DATA, 32'h1b3b_0707);
		reg_wr(`TGLM_H_CMD, 32'h0000_0050);
		repeat (LM) @(posedge i_ref_clk);
		lm_at(8'h00, 1'b0);
		$display("test level metering done");
		report_and_stop();
	end
endmodule : tglm_tb
